// ===== bench/retimer_reg_bank_checker.sv
// checker for the retimer register bank pins and driver settings.
// assumes a bind into the bank; one clock, synchronous reset.
`timescale 1ns/100ps
module retimer_reg_bank_checker
(
    // clock and reset
    input wire logic        sys_clk_in,
    input wire logic        reset_n_in,
    // two-wire pins and strap
    input wire logic        smb_scl_in,
    input wire logic        smb_sda_in,
    input wire logic        smb_sda_out,
    input wire logic        smb_sda_oe_out,
    input wire logic [3:0]  smb_addr_strap_in,
    // driver settings
    input wire logic [15:0] deemph_level_out,
    input wire logic [27:0] deemph_tenth_db_out
);
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!reset_n_in);
    ////////////////////////////////////////////////////////////
    property p_level_max;
        deemph_level_out[3:0] <= 4'he && deemph_level_out[7:4] <= 4'he &&
        deemph_level_out[11:8] <= 4'he && deemph_level_out[15:12] <= 4'he;
    endproperty
    a_level_max: assert property (p_level_max)
        else $error("level index above fourteen");
    property p_tenth_ch0;
        deemph_tenth_db_out[6:0] ==
            retimer_pkg::DEEMPH_TENTH_DB[deemph_level_out[3:0]];
    endproperty
    a_tenth_ch0: assert property (p_tenth_ch0)
        else $error("channel 0 attenuation does not match level");
    property p_tenth_ch2;
        deemph_tenth_db_out[20:14] ==
            retimer_pkg::DEEMPH_TENTH_DB[deemph_level_out[11:8]];
    endproperty
    a_tenth_ch2: assert property (p_tenth_ch2)
        else $error("channel 2 attenuation does not match level");
    property p_tenth_follows;
        $changed(deemph_tenth_db_out) |-> $changed(deemph_level_out);
    endproperty
    a_tenth_follows: assert property (p_tenth_follows)
        else $error("attenuation moved without a level change");
    // settings only move after a host write, which lands in scl low
    property p_level_scl_low;
        $changed(deemph_level_out) |->
            !$past(smb_scl_in) && !$past(smb_scl_in, 2);
    endproperty
    a_level_scl_low: assert property (p_level_scl_low)
        else $error("driver setting changed outside a write");
    property p_ack_rise; $rose(smb_sda_oe_out) |-> !$past(smb_scl_in);
    endproperty
    a_ack_rise: assert property (p_ack_rise)
        else $error("data line pulled while scl high");
    property p_ack_hold; $rose(smb_sda_oe_out) |=> smb_sda_oe_out [*6];
    endproperty
    a_ack_hold: assert property (p_ack_hold)
        else $error("data line pull released early");
    property p_sda_low; smb_sda_out == 1'b0; endproperty
    a_sda_low: assert property (p_sda_low)
        else $error("open-drain data output not low");
    c_ack: cover property ($rose(smb_sda_oe_out));
    c_deepest: cover property (deemph_level_out[11:8] == 4'he);
    c_broadcast: cover property (deemph_level_out == 16'h6666);
endmodule
bind retimer_reg_bank_select_deemph retimer_reg_bank_checker u_chk
(
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
    .smb_scl_in(smb_scl_in), .smb_sda_in(smb_sda_in),
    .smb_sda_out(smb_sda_out), .smb_sda_oe_out(smb_sda_oe_out),
    .smb_addr_strap_in(smb_addr_strap_in),
    .deemph_level_out(deemph_level_out),
    .deemph_tenth_db_out(deemph_tenth_db_out)
);

// ===== bench/smbus_host_model.sv
// behavioural two-wire host reading and writing bank registers.
// assumes the bench forms the pulled-up data line from all enables.
`timescale 1ns/100ps
module smbus_host_model
(
    // clock
    input  wire logic sys_clk_in,
    // bus lines
    input  wire logic sda_line_in,
    output logic      scl_out,
    output logic      sda_low_out
);
    // clocks per scl phase, above the minimum of four
    localparam int HALF = 8;
    logic [6:0] dev_addr = 7'h1b;
    int         nacks = 0;
    initial
    begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    ////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_in);
    endtask
    // data moves mid-low and is sampled mid-high
    task automatic put_bit(input logic b, output logic r);
        tick(HALF / 2);
        sda_low_out <= !b;
        tick(HALF / 2);
        scl_out <= 1'b1;
        tick(HALF / 2);
        r = sda_line_in;
        tick(HALF / 2);
        scl_out <= 1'b0;
    endtask
    // start: sda falls under high scl; stop: sda rises, scl stays high
    task automatic bus_cond(input logic is_start);
        tick(HALF / 2);
        sda_low_out <= !is_start;
        tick(HALF / 2);
        scl_out <= 1'b1;
        tick(HALF);
        sda_low_out <= is_start;
        tick(HALF);
        scl_out <= !is_start;
    endtask
    task automatic send_byte(input logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            put_bit(d[i], r);
        put_bit(1'b1, r);
        if (r)
            nacks++;
    endtask
    // bench passes documented register addresses only
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        bus_cond(1'b1);
        send_byte({dev_addr, 1'b0});
        send_byte(a);
        send_byte(d);
        bus_cond(1'b0);
    endtask
    // single-byte read ends with a not-acknowledge
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        logic r;
        bus_cond(1'b1);
        send_byte({dev_addr, 1'b0});
        send_byte(a);
        bus_cond(1'b1);
        send_byte({dev_addr, 1'b1});
        for (int i = 7; i >= 0; i--)
            put_bit(1'b1, d[i]);
        put_bit(1'b1, r);
        bus_cond(1'b0);
    endtask
endmodule

// ===== bench/tb_top.sv
// bench for the register bank: host model, register tests, verdict.
// assumes the host model and bound checker are compiled first.
`timescale 1ns/100ps
module tb_top;
    logic        sys_clk_in;
    logic        reset_n_in;
    logic [3:0]  strap;
    logic        scl;
    logic        host_low;
    logic        sda_oe;
    logic        sda_line;
    logic [15:0] level;
    logic [27:0] tenth;
    logic [7:0]  rd;
    int          num_errors = 0;
    int          compares = 0;
    int          cycles = 0;
    int          exp_lvl [4] = '{default: 0};
    int          exp_ten [4] = '{default: 0};
    // tenths of a dB by code, range bit set and range bit clear
    int          ten_r1 [8] = '{0, 9, 20, 33, 39, 50, 60, 90};
    int          ten_r0 [8] = '{0, 15, 28, 35, 45, 56, 75, 120};
    // pulled-up open-drain data line
    assign sda_line = !(host_low || sda_oe);
    initial
    begin
        sys_clk_in = 1'b0;
        forever #25 sys_clk_in = ~sys_clk_in;
    end
    retimer_reg_bank_select_deemph dut
    (
        .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
        .smb_scl_in(scl), .smb_sda_in(sda_line), .smb_sda_out(),
        .smb_sda_oe_out(sda_oe), .smb_addr_strap_in(strap),
        .deemph_level_out(level), .deemph_tenth_db_out(tenth)
    );
    smbus_host_model host
    (
        .sys_clk_in(sys_clk_in), .sda_line_in(sda_line),
        .scl_out(scl), .sda_low_out(host_low)
    );
    ////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %0t byte %h not %h", $time, got, exp);
        end
    endtask
    task automatic cmp_out();
        logic [15:0] el;
        logic [27:0] et;
        for (int c = 0; c < 4; c++)
        begin
            el[4*c +: 4] = 4'(exp_lvl[c]);
            et[7*c +: 7] = 7'(exp_ten[c]);
        end
        compares++;
        if (level !== el || tenth !== et)
        begin
            num_errors++;
            $display("CHECK FAILED %0t driver %h %h", $time, level, tenth);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.write_reg(a, d);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        host.read_reg(a, rd);
        cmp8(rd, exp);
    endtask
    // expected setting of one channel after v lands in 0x15
    task automatic set_exp(input int ch, input logic [7:0] v);
        exp_lvl[ch] = (v[2:0] == 3'h0) ? 0 : 2 * int'(v[2:0]) - int'(v[6]);
        exp_ten[ch] = v[6] ? ten_r1[v[2:0]] : ten_r0[v[2:0]];
    endtask
    always @(posedge sys_clk_in)
    begin
        cycles <= cycles + 1;
        if (cycles == 90000)
        begin
            num_errors++;
            report_and_stop();
        end
    end
    initial
    begin
        reset_n_in = 1'b0;
        strap = 4'h3;
        repeat (6) @(posedge sys_clk_in);
        reset_n_in <= 1'b1;
        repeat (10) @(posedge sys_clk_in);
        cmp_out();
        rd_chk(8'hff, 8'h00);
        rd_chk(8'h00, 8'h30);
        rd_chk(8'h01, retimer_pkg::DEVICE_ID_VALUE);
        wr(8'h00, 8'hc0);
        rd_chk(8'h00, 8'h30);
        $display("test shared_set done");
        for (int c = 0; c < 4; c++)
        begin
            wr(8'hff, 8'(4 + c));
            wr(8'h00, 8'(16 + c));
            wr(8'h15, 8'(c + 1));
            set_exp(c, 8'(c + 1));
        end
        cmp_out();
        for (int c = 0; c < 4; c++)
        begin
            wr(8'hff, 8'(4 + c));
            rd_chk(8'hff, 8'(4 + c));
            rd_chk(8'h00, 8'(16 + c));
        end
        wr(8'hff, 8'h00);
        rd_chk(8'h00, 8'h30);
        $display("test channel_sets done");
        wr(8'hff, 8'h06);
        for (int v = 0; v < 16; v++)
        begin
            wr(8'h15, {1'b0, v[3], 3'h0, v[2:0]});
            set_exp(2, {1'b0, v[3], 3'h0, v[2:0]});
            cmp_out();
        end
        rd_chk(8'h15, 8'h47);
        wr(8'h15, rd & 8'hbf);
        set_exp(2, 8'h07);
        cmp_out();
        $display("test deemph_table done");
        wr(8'hff, 8'h0d);
        wr(8'h15, 8'h03);
        for (int c = 0; c < 4; c++)
            set_exp(c, 8'h03);
        cmp_out();
        rd_chk(8'hff, 8'h0d);
        wr(8'hff, 8'h01);
        wr(8'h00, 8'h77);
        rd_chk(8'h00, 8'h30);
        wr(8'hff, 8'h08);
        wr(8'h00, 8'h66);
        wr(8'hff, 8'h05);
        rd_chk(8'h00, 8'h11);
        wr(8'h15, 8'h41);
        set_exp(1, 8'h41);
        cmp_out();
        $display("test broadcast done");
        host.dev_addr = 7'h18;
        wr(8'h15, 8'h07);
        host.dev_addr = 7'h1b;
        cmp8(8'(host.nacks), 8'h03);
        cmp_out();
        $display("test wrong_address done");
        report_and_stop();
    end
endmodule

// ===== src/chan_reg_set.sv
// one channel register set: general register and de-emphasis control.
// assumes write strobe and addresses come from the bank on the same clock.
`timescale 1ns/100ps

module chan_reg_set
(
    // clock and reset
    input  wire logic       sys_clk_in,
    input  wire logic       reset_n_in,
    // register access
    input  wire logic       wr_en_in,
    input  wire logic [7:0] wr_addr_in,
    input  wire logic [7:0] wr_data_in,
    input  wire logic [7:0] rd_addr_in,
    output logic      [7:0] rd_data_out,
    // driver setting
    output logic      [3:0] level_out,
    output logic      [6:0] tenth_db_out
);

    logic [7:0] general_q;
    logic [2:0] code_q;
    logic       range_q;
    logic [3:0] level_q;
    logic [6:0] tenth_q;

    wire        wr_general = wr_en_in &&
                             (wr_addr_in == retimer_pkg::CHAN_GENERAL_OFS);
    wire        wr_deemph  = wr_en_in &&
                             (wr_addr_in == retimer_pkg::DEEMPH_CTRL_OFS);
    wire  [7:0] deemph_rd  = {1'b0, range_q, 3'h0, code_q};

    // level = 2*code - 1, plus one more step when the range bit is clear
    wire  [3:0] level_d = (code_q == 3'h0) ? 4'h0 :
                          4'({code_q, 1'b0} - 4'h1 + {3'h0, ~range_q});

    assign rd_data_out = (rd_addr_in == retimer_pkg::CHAN_GENERAL_OFS) ?
                         general_q :
                         (rd_addr_in == retimer_pkg::DEEMPH_CTRL_OFS) ?
                         deemph_rd : 8'h00;
    assign level_out    = level_q;
    assign tenth_db_out = tenth_q;

    always_ff @(posedge sys_clk_in)
    begin
        if (!reset_n_in)
        begin
            general_q <= retimer_pkg::CHAN_GENERAL_RST;
            code_q    <= retimer_pkg::DEEMPH_CTRL_RST[2:0];
            range_q   <= retimer_pkg::DEEMPH_CTRL_RST[6];
        end
        else
        begin
            if (wr_general)
                general_q <= wr_data_in;
            if (wr_deemph)
            begin
                code_q  <= wr_data_in[retimer_pkg::DEEMPH_CODE_LSB +:
                                      retimer_pkg::DEEMPH_CODE_W];
                range_q <= wr_data_in[retimer_pkg::DEEMPH_RANGE_BIT];
            end
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (!reset_n_in)
        begin
            level_q <= 4'h0;
            tenth_q <= 7'h00;
        end
        else
        begin
            level_q <= level_d;
            tenth_q <= retimer_pkg::DEEMPH_TENTH_DB[level_d];
        end
    end

endmodule

// ===== src/retimer_pkg.sv
// constants for the retimer register bank: register-set selection,
// per-channel de-emphasis field and the two-wire slave port.
// assumes one 20 MHz clock and a synchronous active-low reset.
//
// Contract
// - fifteen de-emphasis levels; code 000 is 0 dB
// - codes 1-3 map by range bit
// - codes 4-7 map by range bit
// - shared set plus one set per channel
// - writes to 0xff always reach selector
// - selector bit 2 clear routes to shared set
// - shared 0x00 returned while bit 2 clear
// - bit 2 set reads selected channel
// - bits 3 and 2 set broadcast writes
// - writes to read-only registers are ignored
package retimer_pkg;

    localparam int CHANNELS = 4;

    // register offsets
    localparam logic [7:0] SHARED_ADDR_OFS   = 8'h00;
    localparam logic [7:0] SHARED_ID_OFS     = 8'h01;
    localparam logic [7:0] SHARED_SCRATCH_OFS = 8'h02;
    localparam logic [7:0] CHAN_GENERAL_OFS  = 8'h00;
    localparam logic [7:0] DEEMPH_CTRL_OFS   = 8'h15;
    localparam logic [7:0] SELECTOR_OFS      = 8'hff;

    // selector fields
    localparam int SEL_CHAN_LSB      = 0;
    localparam int SEL_CHAN_W        = 2;
    localparam int SEL_SET_ENABLE_BIT = 2;
    localparam int SEL_BROADCAST_BIT = 3;
    localparam int SEL_STORED_W      = 4;

    // de-emphasis control fields
    localparam int DEEMPH_CODE_LSB  = 0;
    localparam int DEEMPH_CODE_W    = 3;
    localparam int DEEMPH_RANGE_BIT = 6;
    localparam int DEEMPH_LEVEL_W   = 4;
    localparam int DEEMPH_TENTH_W   = 7;

    // reset values
    localparam logic [7:0] SELECTOR_RST    = 8'h00;
    localparam logic [7:0] SCRATCH_RST     = 8'h00;
    localparam logic [7:0] CHAN_GENERAL_RST = 8'h00;
    localparam logic [7:0] DEEMPH_CTRL_RST = 8'h00;

    // device identity byte; value is arbitrary
    localparam logic [7:0] DEVICE_ID_VALUE = 8'h5a;

    // strapped address field sits in the top nibble of shared 0x00
    localparam int STRAP_W   = 4;
    localparam int STRAP_LSB = 4;
    localparam logic [6:0] SLAVE_BASE_ADDR = 7'h18;

    localparam logic [3:0] BYTE_BITS = 4'h8;

    // attenuation in tenths of a dB, indexed by level 0 (0 dB) .. 14
    localparam logic [14:0][6:0] DEEMPH_TENTH_DB = {
        7'h78, 7'h5a, 7'h4b, 7'h3c, 7'h38, 7'h32, 7'h2d, 7'h27,
        7'h23, 7'h21, 7'h1c, 7'h14, 7'h0f, 7'h09, 7'h00
    };

    typedef enum logic [2:0] {
        LINK_IDLE,
        LINK_ADDR,
        LINK_CMD,
        LINK_WDATA,
        LINK_RDATA
    } link_state_t;

endpackage

// ===== src/retimer_reg_bank_select_deemph.sv
// register bank of a four-channel retimer behind a two-wire slave port:
// shared set, channel sets, set selector and broadcast writes.
// assumes scl/sda and address straps arrive asynchronously from pins.
`timescale 1ns/100ps

module retimer_reg_bank_select_deemph
(
    // clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        reset_n_in,
    // two-wire slave pins
    input  wire logic        smb_scl_in,
    input  wire logic        smb_sda_in,
    output logic             smb_sda_out,
    output logic             smb_sda_oe_out,
    // address strap
    input  wire logic [3:0]  smb_addr_strap_in,
    // per-channel driver settings, channel n in slice n
    output logic      [15:0] deemph_level_out,
    output logic      [27:0] deemph_tenth_db_out
);

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic       scl_s1_q;
    logic       scl_s2_q;
    logic       scl_s3_q;
    logic       sda_s1_q;
    logic       sda_s2_q;
    logic       sda_s3_q;
    logic [3:0] strap_s1_q;
    logic [3:0] strap_s2_q;
    logic [3:0] strap_q;
    logic       strap_taken_q;

    always_ff @(posedge sys_clk_in)
    begin
        if (!reset_n_in)
        begin
            scl_s1_q   <= 1'b1;
            scl_s2_q   <= 1'b1;
            scl_s3_q   <= 1'b1;
            sda_s1_q   <= 1'b1;
            sda_s2_q   <= 1'b1;
            sda_s3_q   <= 1'b1;
            strap_s1_q <= 4'h0;
            strap_s2_q <= 4'h0;
        end
        else
        begin
            scl_s1_q   <= smb_scl_in;
            scl_s2_q   <= scl_s1_q;
            scl_s3_q   <= scl_s2_q;
            sda_s1_q   <= smb_sda_in;
            sda_s2_q   <= sda_s1_q;
            sda_s3_q   <= sda_s2_q;
            strap_s1_q <= smb_addr_strap_in;
            strap_s2_q <= strap_s1_q;
        end
    end

    // strap is caught once, after the synchroniser has filled
    logic [1:0] strap_wait_q;

    always_ff @(posedge sys_clk_in)
    begin
        if (!reset_n_in)
        begin
            strap_wait_q  <= 2'h0;
            strap_taken_q <= 1'b0;
            strap_q       <= 4'h0;
        end
        else if (!strap_taken_q)
        begin
            strap_wait_q <= 2'(strap_wait_q + 2'h1);
            if (strap_wait_q == 2'h3)
            begin
                strap_q       <= strap_s2_q;
                strap_taken_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus conditions

    retimer_pkg::link_state_t state_q;
    logic [3:0] bit_cnt_q;
    logic       ack_q;
    logic       rw_q;
    logic       nack_q;
    logic [7:0] shift_q;
    logic [7:0] tx_q;
    logic [7:0] ptr_q;
    logic       oe_q;
    logic [7:0] rd_data;

    wire        scl_rise  = scl_s2_q & ~scl_s3_q;
    wire        scl_fall  = ~scl_s2_q & scl_s3_q;
    wire        bus_start = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
    wire        bus_stop  = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;
    wire        active    = (state_q != retimer_pkg::LINK_IDLE);
    wire        byte_done = scl_fall & active & ~ack_q &
                            (bit_cnt_q == retimer_pkg::BYTE_BITS);
    wire  [6:0] own_addr  = 7'(retimer_pkg::SLAVE_BASE_ADDR +
                               {3'h0, strap_q});
    wire        addr_hit  = (shift_q[7:1] == own_addr);
    wire        wr_pulse  = byte_done &
                            (state_q == retimer_pkg::LINK_WDATA);

    ////////////////////////////////////////////////////////////////////////
    // slave state machine

    always_ff @(posedge sys_clk_in)
    begin
        if (!reset_n_in)
            shift_q <= 8'h00;
        else if (scl_rise && active && !ack_q)
            shift_q <= {shift_q[6:0], sda_s2_q};
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (!reset_n_in)
        begin
            state_q   <= retimer_pkg::LINK_IDLE;
            bit_cnt_q <= 4'h0;
            ack_q     <= 1'b0;
            rw_q      <= 1'b0;
            nack_q    <= 1'b0;
            tx_q      <= 8'h00;
            ptr_q     <= 8'h00;
            oe_q      <= 1'b0;
        end
        else if (bus_start)
        begin
            state_q   <= retimer_pkg::LINK_ADDR;
            bit_cnt_q <= 4'h0;
            ack_q     <= 1'b0;
            oe_q      <= 1'b0;
        end
        else if (bus_stop)
        begin
            state_q <= retimer_pkg::LINK_IDLE;
            ack_q   <= 1'b0;
            oe_q    <= 1'b0;
        end
        else if (scl_rise && active)
        begin
            if (ack_q)
                nack_q <= sda_s2_q;
            else
                bit_cnt_q <= 4'(bit_cnt_q + 4'h1);
        end
        else if (byte_done)
        begin
            bit_cnt_q <= 4'h0;
            ack_q     <= 1'b1;
            case (state_q)
                retimer_pkg::LINK_ADDR:
                begin
                    rw_q <= shift_q[0];
                    oe_q <= addr_hit;
                    if (!addr_hit)
                    begin
                        state_q <= retimer_pkg::LINK_IDLE;
                        ack_q   <= 1'b0;
                    end
                end
                retimer_pkg::LINK_CMD:
                begin
                    ptr_q <= shift_q;
                    oe_q  <= 1'b1;
                end
                retimer_pkg::LINK_WDATA:
                begin
                    ptr_q <= 8'(ptr_q + 8'h01);
                    oe_q  <= 1'b1;
                end
                default:
                    oe_q <= 1'b0;
            endcase
        end
        else if (scl_fall && ack_q)
        begin
            ack_q     <= 1'b0;
            bit_cnt_q <= 4'h0;
            oe_q      <= 1'b0;
            case (state_q)
                retimer_pkg::LINK_ADDR:
                begin
                    if (rw_q)
                    begin
                        state_q <= retimer_pkg::LINK_RDATA;
                        tx_q    <= rd_data;
                        oe_q    <= ~rd_data[7];
                        ptr_q   <= 8'(ptr_q + 8'h01);
                    end
                    else
                        state_q <= retimer_pkg::LINK_CMD;
                end
                retimer_pkg::LINK_CMD:
                    state_q <= retimer_pkg::LINK_WDATA;
                retimer_pkg::LINK_RDATA:
                begin
                    if (nack_q)
                        state_q <= retimer_pkg::LINK_IDLE;
                    else
                    begin
                        tx_q  <= rd_data;
                        oe_q  <= ~rd_data[7];
                        ptr_q <= 8'(ptr_q + 8'h01);
                    end
                end
                default:
                    state_q <= state_q;
            endcase
        end
        else if (scl_fall && state_q == retimer_pkg::LINK_RDATA)
        begin
            tx_q <= {tx_q[6:0], 1'b0};
            oe_q <= ~tx_q[6];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register decode and shared set

    logic [3:0] sel_q;
    logic [7:0] scratch_q;

    wire        set_enable = sel_q[retimer_pkg::SEL_SET_ENABLE_BIT];
    wire        broadcast  = sel_q[retimer_pkg::SEL_BROADCAST_BIT];
    wire  [1:0] chan_sel   = sel_q[retimer_pkg::SEL_CHAN_LSB +:
                                   retimer_pkg::SEL_CHAN_W];
    wire        hit_sel    = (ptr_q == retimer_pkg::SELECTOR_OFS);
    wire        wr_sel     = wr_pulse & hit_sel;
    wire        wr_shared  = wr_pulse & ~hit_sel & ~set_enable;
    wire        wr_chan    = wr_pulse & ~hit_sel & set_enable;
    // only the scratch register takes shared writes; 0x00 and 0x01 stay
    wire        wr_scratch = wr_shared &
                             (ptr_q == retimer_pkg::SHARED_SCRATCH_OFS);

    wire  [7:0] shared_rd  =
        (ptr_q == retimer_pkg::SHARED_ADDR_OFS)    ?
            {strap_q, 4'h0} :
        (ptr_q == retimer_pkg::SHARED_ID_OFS)      ?
            retimer_pkg::DEVICE_ID_VALUE :
        (ptr_q == retimer_pkg::SHARED_SCRATCH_OFS) ? scratch_q : 8'h00;

    always_ff @(posedge sys_clk_in)
    begin
        if (!reset_n_in)
        begin
            sel_q     <= retimer_pkg::SELECTOR_RST[3:0];
            scratch_q <= retimer_pkg::SCRATCH_RST;
        end
        else
        begin
            if (wr_sel)
                sel_q <= wr_data_sel(shift_q);
            if (wr_scratch)
                scratch_q <= shift_q;
        end
    end

    function automatic logic [3:0] wr_data_sel(input logic [7:0] d);
        wr_data_sel = d[retimer_pkg::SEL_STORED_W-1:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // channel sets

    logic [3:0][7:0] chan_rd;
    logic [3:0]      chan_wr;

    genvar ch;
    generate
        for (ch = 0; ch < retimer_pkg::CHANNELS; ch++)
        begin : g_chan
            // one set per channel; broadcast with selector bit 2 set hits all of them
            assign chan_wr[ch] = wr_chan &
                                 (broadcast ||
                                  chan_sel == 2'(ch));
            chan_reg_set u_chan
            (
                .sys_clk_in   (sys_clk_in),
                .reset_n_in   (reset_n_in),
                .wr_en_in     (chan_wr[ch]),
                .wr_addr_in   (ptr_q),
                .wr_data_in   (shift_q),
                .rd_addr_in   (ptr_q),
                .rd_data_out  (chan_rd[ch]),
                .level_out    (deemph_level_out[ch*4 +: 4]),
                .tenth_db_out (deemph_tenth_db_out[ch*7 +: 7])
            );
        end
    endgenerate

    // read source follows the selector
    assign rd_data = hit_sel    ? {4'h0, sel_q} :
                     set_enable ? chan_rd[chan_sel] :
                     shared_rd;

    ////////////////////////////////////////////////////////////////////////
    // pin drive: open drain, only ever pulls low

    logic sda_level_q;

    always_ff @(posedge sys_clk_in)
    begin
        if (!reset_n_in)
            sda_level_q <= 1'b0;
        else
            sda_level_q <= 1'b0;
    end

    assign smb_sda_out    = sda_level_q;
    assign smb_sda_oe_out = oe_q;

endmodule
